// ==== hdl/global_config_reset_control.v ====
// global configuration, reset commands and block soft resets
//
// How it works
// - regulator select bit picks 1.25V or 1.32V
// - crystal wait time taken from three-bit code
// - four-bit configuration select, reset to 4
// - cleared hold bit holds both input dividers
// - output enable bit, reset 1, drives outputs
// - align trigger synchronises output dividers, and loop dividers only when the digital loop is enabled
// - outputs squelched about ten microseconds during sync
// - reinit trigger restarts from crystal wait, then oscillator calibration
// - bias calibration held reset while bit set
// - time-to-digital held reset while bit set
// - digital loop held reset while bit set
// - negative input activity monitor held reset
// - positive input activity monitor held reset
// - crystal loss monitor held reset while set
// - negative input loss monitor held reset
// - positive input loss monitor held reset
// - program memory logic held reset while set
`timescale 1ns/10ps
`include "global_config_reset_consts.vh"
module global_config_reset_control #(
  parameter TIMER_WIDTH   = 20,
  parameter CYCLES_PER_US = `CYCLES_PER_US,
  parameter SQUELCH_COUNT = `SQUELCH_CYCLES
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // serial register port, byte wide
  input  wire [3:0]  regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regWriteData,
  output reg  [7:0]  regReadData,
  // device context
  input  wire        digitalLoopEnabled,
  input  wire        calibrationDone,
  // configuration outputs
  output reg         regulatorHighSelect,
  output reg  [2:0]  crystal_startup_wait_code,
  output reg  [3:0]  configSelect,
  output reg         inputDividerHoldN,
  output reg         globalOutputEnable,
  // start-up and synchronisation controls
  output reg         startCalibration,
  output reg         outputDividerSync,
  output reg         feedbackDividerSync,
  output reg         outputSquelch,
  output reg         crystalWaitActive,
  // block soft resets
  output wire        bias_calibration_soft_reset,
  output wire        time_to_digital_soft_reset,
  output wire        digital_loop_soft_reset,
  output wire        negative_input_activity_reset,
  output wire        positive_input_activity_reset,
  output wire        crystal_signal_loss_reset,
  output wire        negative_input_signal_loss_reset,
  output wire        positive_input_signal_loss_reset,
  output wire        program_memory_soft_reset
);

  localparam ST_IDLE      = 2'h0;
  localparam ST_XTAL_WAIT = 2'h1;
  localparam ST_CALIBRATE = 2'h2;
  localparam ST_SQUELCH   = 2'h3;

  // crystal wait per code, in microseconds, sized to the timer
  localparam [TIMER_WIDTH-1:0] WAIT_US_CODE0 = `WAIT_TIME_1_US;
  localparam [TIMER_WIDTH-1:0] WAIT_US_CODE1 = `WAIT_TIME_2_US;
  localparam [TIMER_WIDTH-1:0] WAIT_US_CODE2 = `WAIT_TIME_3_US;
  localparam [TIMER_WIDTH-1:0] WAIT_US_CODE3 = `WAIT_TIME_4_US;
  localparam [TIMER_WIDTH-1:0] WAIT_US_CODE4 = `WAIT_TIME_5_US;
  localparam [TIMER_WIDTH-1:0] WAIT_US_CODE5 = `WAIT_TIME_6_US;
  localparam [TIMER_WIDTH-1:0] WAIT_US_CODE6 = `WAIT_TIME_7_US;

  // writable bits of the soft reset word
  localparam [15:0] SOFT_MASK = `MASK_BLOCK_SOFT_RESETS;

  reg  [7:0]             overallConfig;
  reg  [7:0]             resetCommands;
  reg  [15:0]            softResets;
  reg  [1:0]             state;
  reg  [1:0]             next_state;
  reg                    timerLoad;
  reg  [TIMER_WIDTH-1:0] timerValue;
  reg  [TIMER_WIDTH-1:0] waitUs;
  wire                   timerBusy;
  wire                   timerDone;
  wire                   alignRise;
  wire                   reinitRise;

  wire writeCfg = regWrite && (regAddr == `OFS_DEVICE_OVERALL_CONFIG);
  wire writeCmd = regWrite && (regAddr == `OFS_DEVICE_RESET_COMMANDS);
  wire writeLo  = regWrite && (regAddr == `OFS_BLOCK_SOFT_RESETS_LO);
  wire writeHi  = regWrite && (regAddr == `OFS_BLOCK_SOFT_RESETS_HI);

  // triggers fire on a written 0-to-1 edge only
  assign alignRise  = writeCmd && regWriteData[`BIT_DIVIDER_ALIGN]
                      && !resetCommands[`BIT_DIVIDER_ALIGN];
  assign reinitRise = writeCmd && regWriteData[`BIT_LOOP_REINIT]
                      && !resetCommands[`BIT_LOOP_REINIT];

  // register file
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      overallConfig <= `RST_DEVICE_OVERALL_CONFIG;
      resetCommands <= `RST_DEVICE_RESET_COMMANDS;
      softResets    <= `RST_BLOCK_SOFT_RESETS;
    end else begin
      if (writeCfg)
        overallConfig <= regWriteData;
      if (writeCmd)
        resetCommands <= regWriteData & `MASK_DEVICE_RESET_COMMANDS;
      if (writeLo)
        softResets[7:0] <= regWriteData;
      if (writeHi)
        softResets[15:8] <= regWriteData & SOFT_MASK[15:8];
    end
  end

  // read data, unmapped addresses read zero
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `OFS_DEVICE_OVERALL_CONFIG: regReadData <= overallConfig;
        `OFS_DEVICE_RESET_COMMANDS: regReadData <= resetCommands;
        `OFS_BLOCK_SOFT_RESETS_LO:  regReadData <= softResets[7:0];
        `OFS_BLOCK_SOFT_RESETS_HI:  regReadData <= softResets[15:8];
        default:                    regReadData <= 8'h00;
      endcase
    end
  end

  // configuration outputs
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regulatorHighSelect       <= 1'b0;
      crystal_startup_wait_code <= 3'h0;
      configSelect              <= 4'h4;
      inputDividerHoldN         <= 1'b1;
      globalOutputEnable        <= 1'b1;
    end else begin
      regulatorHighSelect       <= overallConfig[`BIT_REGULATOR_SELECT];
      crystal_startup_wait_code <= overallConfig[`POS_WAIT_CODE_HI:`POS_WAIT_CODE_LO];
      configSelect              <= overallConfig[`POS_CONFIG_SELECT_HI:`POS_CONFIG_SELECT_LO];
      inputDividerHoldN         <= resetCommands[`BIT_DIVIDER_HOLD_N];
      globalOutputEnable        <= resetCommands[`BIT_GLOBAL_OUTPUT_ENABLE];
    end
  end

  // crystal wait in microseconds per code; reserved code uses 1 ms
  always @* begin
    case (overallConfig[`POS_WAIT_CODE_HI:`POS_WAIT_CODE_LO])
      3'h1:    waitUs = WAIT_US_CODE1;
      3'h2:    waitUs = WAIT_US_CODE2;
      3'h3:    waitUs = WAIT_US_CODE3;
      3'h4:    waitUs = WAIT_US_CODE4;
      3'h5:    waitUs = WAIT_US_CODE5;
      3'h6:    waitUs = WAIT_US_CODE6;
      default: waitUs = WAIT_US_CODE0;
    endcase
  end

  // sequencer: reinit wins over align when both arrive together
  always @* begin
    next_state = state;
    timerLoad  = 1'b0;
    timerValue = SQUELCH_COUNT[TIMER_WIDTH-1:0];
    case (state)
      ST_IDLE: begin
        if (reinitRise) begin
          next_state = ST_XTAL_WAIT;
          timerLoad  = 1'b1;
          timerValue = waitUs * CYCLES_PER_US[TIMER_WIDTH-1:0];
        end else if (alignRise) begin
          next_state = ST_SQUELCH;
          timerLoad  = 1'b1;
        end
      end
      ST_XTAL_WAIT: begin
        if (timerDone)
          next_state = ST_CALIBRATE;
      end
      ST_CALIBRATE: begin
        if (calibrationDone) begin
          next_state = ST_SQUELCH;
          timerLoad  = 1'b1;
        end
      end
      ST_SQUELCH: begin
        if (timerDone)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state               <= ST_IDLE;
      startCalibration    <= 1'b0;
      outputDividerSync   <= 1'b0;
      feedbackDividerSync <= 1'b0;
      outputSquelch       <= 1'b0;
      crystalWaitActive   <= 1'b0;
    end else begin
      state               <= next_state;
      startCalibration    <= (state == ST_XTAL_WAIT) && timerDone;
      outputDividerSync   <= timerLoad && (next_state == ST_SQUELCH);
      feedbackDividerSync <= timerLoad && (next_state == ST_SQUELCH)
                             && digitalLoopEnabled;
      outputSquelch       <= (next_state == ST_SQUELCH);
      crystalWaitActive   <= (next_state == ST_XTAL_WAIT);
    end
  end

  startup_timer #(
    .WIDTH (TIMER_WIDTH)
  ) u_timer (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .load      (timerLoad),
    .loadValue (timerValue),
    .busy      (timerBusy),
    .done      (timerDone)
  );

  // soft resets held while their bits are set
  assign bias_calibration_soft_reset      = softResets[8];
  assign time_to_digital_soft_reset       = softResets[7];
  assign digital_loop_soft_reset          = softResets[6];
  assign negative_input_activity_reset    = softResets[5];
  assign positive_input_activity_reset    = softResets[4];
  assign crystal_signal_loss_reset        = softResets[3];
  assign negative_input_signal_loss_reset = softResets[2];
  assign positive_input_signal_loss_reset = softResets[1];
  assign program_memory_soft_reset        = softResets[0];

endmodule // global_config_reset_control

// ==== hdl/global_config_reset_consts.vh ====
// constants for the global configuration and reset control block
`ifndef GLOBAL_CONFIG_RESET_CONSTS_VH
`define GLOBAL_CONFIG_RESET_CONSTS_VH

// register offsets (byte addresses within the global block)
`define OFS_DEVICE_OVERALL_CONFIG 4'h0
`define OFS_DEVICE_RESET_COMMANDS 4'h1
`define OFS_BLOCK_SOFT_RESETS_LO  4'h2
`define OFS_BLOCK_SOFT_RESETS_HI  4'h3

// device_overall_config fields
`define BIT_REGULATOR_SELECT      7
`define POS_WAIT_CODE_HI          6
`define POS_WAIT_CODE_LO          4
`define POS_CONFIG_SELECT_HI      3
`define POS_CONFIG_SELECT_LO      0
`define RST_DEVICE_OVERALL_CONFIG 8'h04

// device_reset_commands fields
`define BIT_DIVIDER_HOLD_N        5
`define BIT_GLOBAL_OUTPUT_ENABLE  4
`define BIT_DIVIDER_ALIGN         1
`define BIT_LOOP_REINIT           0
`define RST_DEVICE_RESET_COMMANDS 8'h30
`define MASK_DEVICE_RESET_COMMANDS 8'h33

// block_soft_resets fields
`define RST_BLOCK_SOFT_RESETS     16'h0000
`define MASK_BLOCK_SOFT_RESETS    16'h09FF
`define NUM_SOFT_RESETS           9

// timing
`define CLOCK_FREQ_HZ             20000000
`define SQUELCH_TIME_NS           10000
`define SQUELCH_CYCLES            ((`SQUELCH_TIME_NS * (`CLOCK_FREQ_HZ / 1000000)) / 1000)
`define WAIT_TIME_1_US            1000
`define WAIT_TIME_2_US            2500
`define WAIT_TIME_3_US            5000
`define WAIT_TIME_4_US            7500
`define WAIT_TIME_5_US            10000
`define WAIT_TIME_6_US            500
`define WAIT_TIME_7_US            15000
`define CYCLES_PER_US             (`CLOCK_FREQ_HZ / 1000000)

`endif

// ==== hdl/startup_timer.v ====
// down-counter that measures one start-up or squelch interval
`timescale 1ns/10ps
module startup_timer #(
  parameter WIDTH = 20
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rstn,
  // control
  input  wire             load,
  input  wire [WIDTH-1:0] loadValue,
  // status
  output reg              busy,
  output wire             done
);

  reg [WIDTH-1:0] count;

  assign done = busy && (count == {{(WIDTH-1){1'b0}}, 1'b1});

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= {WIDTH{1'b0}};
      busy  <= 1'b0;
    end else if (load) begin
      count <= loadValue;
      busy  <= 1'b1;
    end else if (busy) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      if (done)
        busy <= 1'b0;
    end
  end

endmodule // startup_timer

// ==== tb/global_config_reset_control_chk.sv ====
// assertion checker for the global configuration and reset block
`timescale 1ns/10ps
module global_config_reset_control_chk #(parameter SQUELCH_COUNT = 5) (
  // clock, reset, register port
  input wire       core_clk, rstn, regWrite, digitalLoopEnabled,
  input wire [3:0] regAddr,
  input wire [7:0] regWriteData,
  // controls
  input wire       regulatorHighSelect, inputDividerHoldN, globalOutputEnable,
  input wire       outputDividerSync, feedbackDividerSync, outputSquelch, crystalWaitActive,
  input wire [2:0] crystal_startup_wait_code,
  input wire [3:0] configSelect,
  // soft resets
  input wire       bias_calibration_soft_reset, time_to_digital_soft_reset,
  input wire       digital_loop_soft_reset, negative_input_activity_reset,
  input wire       positive_input_activity_reset, crystal_signal_loss_reset,
  input wire       negative_input_signal_loss_reset, positive_input_signal_loss_reset,
  input wire       program_memory_soft_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  reg  [15:0] sqLen;
  reg  [1:0]  trig;
  wire        w1   = regWrite && regAddr == 4'h1;
  wire        idle = !outputSquelch && !crystalWaitActive;
  // squelch run length and stored trigger bits
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sqLen <= 16'h0000;
      trig  <= 2'h0;
    end else begin
      sqLen <= outputSquelch ? sqLen + 16'h0001 : 16'h0000;
      if (w1)
        trig <= regWriteData[1:0];
    end
  end
  property p_cfg;
    regWrite && regAddr == 4'h0 ##1 !(regWrite && regAddr == 4'h0) |=>
      {regulatorHighSelect, crystal_startup_wait_code, configSelect} == $past(regWriteData, 2);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config outputs differ from written byte");
  property p_cmd;
    w1 ##1 !w1 |=>
      {2'h0, inputDividerHoldN, globalOutputEnable, 4'h0} == ($past(regWriteData, 2) & 8'h30);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("hold or enable output differs from written byte");
  property p_softLo;
    regWrite && regAddr == 4'h2 |=> {time_to_digital_soft_reset, digital_loop_soft_reset,
      negative_input_activity_reset, positive_input_activity_reset, crystal_signal_loss_reset,
      negative_input_signal_loss_reset, positive_input_signal_loss_reset,
      program_memory_soft_reset} == $past(regWriteData);
  endproperty
  a_softLo: assert property (p_softLo)
    else $error("low soft reset outputs differ from written byte");
  property p_softHi;
    regWrite && regAddr == 4'h3 |=> {7'h00, bias_calibration_soft_reset} == ($past(regWriteData) & 8'h01);
  endproperty
  a_softHi: assert property (p_softHi)
    else $error("bias calibration reset differs from written bit");
  property p_squelch;
    $fell(outputSquelch) |-> sqLen == SQUELCH_COUNT;
  endproperty
  a_squelch: assert property (p_squelch)
    else $error("squelch length wrong");
  property p_fb;
    feedbackDividerSync |-> outputDividerSync && digitalLoopEnabled;
  endproperty
  a_fb: assert property (p_fb)
    else $error("feedback sync without output sync or loop");
  property p_trigger;
    w1 && regWriteData[1:0] == 2'b10 && !trig[1] && idle |-> ##[1:2] outputDividerSync;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("align write gave no sync pulse");
  property p_noRetrigger;
    w1 && regWriteData[1:0] == 2'b10 && trig[1] |=> !outputDividerSync [*3];
  endproperty
  a_noRetrigger: assert property (p_noRetrigger)
    else $error("repeated align write gave a sync pulse");
  property p_reinit;
    w1 && regWriteData[0] && !trig[0] && idle |-> ##[1:2] crystalWaitActive;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("reinit write gave no crystal wait");
  c_fbSync: cover property (outputDividerSync && feedbackDividerSync);
  c_wait: cover property ($fell(crystalWaitActive));
  c_bias: cover property ($rose(bias_calibration_soft_reset));
endmodule // global_config_reset_control_chk

// ==== tb/global_config_reset_control_bench.sv ====
// self-checking bench for the global configuration and reset block
`timescale 1ns/10ps
module global_config_reset_control_bench;
  logic       core_clk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic       digitalLoopEnabled = 1'b1, calibrationDone = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWriteData = 8'h00, d;
  logic [7:0] rv [6] = '{8'h04, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00};
  wire  [7:0] regReadData;
  wire        regulatorHighSelect, inputDividerHoldN, globalOutputEnable, startCalibration;
  wire        outputDividerSync, feedbackDividerSync, outputSquelch, crystalWaitActive;
  wire  [2:0] crystal_startup_wait_code;
  wire  [3:0] configSelect;
  wire        bias_calibration_soft_reset, time_to_digital_soft_reset, digital_loop_soft_reset;
  wire        negative_input_activity_reset, positive_input_activity_reset;
  wire        crystal_signal_loss_reset, negative_input_signal_loss_reset;
  wire        positive_input_signal_loss_reset, program_memory_soft_reset;
  wire  [8:0] softVec = {bias_calibration_soft_reset, time_to_digital_soft_reset,
    digital_loop_soft_reset, negative_input_activity_reset, positive_input_activity_reset,
    crystal_signal_loss_reset, negative_input_signal_loss_reset,
    positive_input_signal_loss_reset, program_memory_soft_reset};
  int         nFail = 0, totalChecks = 0, len, nSync, nFb, c;
  global_config_reset_control #(.CYCLES_PER_US(1), .SQUELCH_COUNT(5)) dut_u (.*);
  always #25 core_clk = ~core_clk;
  task automatic closeOut;
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge core_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = v;
    @(negedge core_clk);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge core_clk);
    regRead = 1'b0;
    check("read data", regReadData, exp);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return outputSquelch;
      1: return crystalWaitActive;
      default: return startCalibration;
    endcase
  endfunction
  // length of the next high run of a level, counting sync pulses meanwhile
  task automatic measure(input int s);
    len = 0;
    nSync = 0;
    nFb = 0;
    for (int i = 0; i < 6000 && !(len > 0 && !pick(s)); i++) begin
      nSync += outputDividerSync;
      nFb += feedbackDividerSync;
      len += pick(s);
      @(negedge core_clk);
    end
    if (len == 0 || pick(s)) begin
      nFail++;
      closeOut();
    end
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    for (c = 0; c < 6; c++) rd(c[3:0], rv[c]);
    check("reset outputs", {inputDividerHoldN, globalOutputEnable, configSelect}, 6'h34);
    for (c = 0; c < 8; c++) begin
      d = {c[0], c[2:0], 4'hF - c[3:0]};
      wr(4'h0, d);
      rd(4'h0, d);
      check("config outputs", {regulatorHighSelect, crystal_startup_wait_code, configSelect}, d);
    end
    wr(4'h1, 8'hCC);
    rd(4'h1, 8'h00);
    check("hold and enable", {inputDividerHoldN, globalOutputEnable}, 2'h0);
    wr(4'h1, 8'h30);
    wr(4'h1, 8'h32);
    measure(0);
    check("squelch length", len, 5);
    check("sync pulses", {nSync[7:0], nFb[7:0]}, 16'h0101);
    wr(4'h1, 8'h32);
    repeat (20) @(negedge core_clk);
    check("retrigger squelch", outputSquelch, 1'b0);
    wr(4'h1, 8'h30);
    digitalLoopEnabled = 1'b0;
    wr(4'h1, 8'h32);
    measure(0);
    check("sync without loop", {nSync[7:0], nFb[7:0]}, 16'h0100);
    wr(4'h1, 8'h30);
    digitalLoopEnabled = 1'b1;
    wr(4'h0, 8'h54);
    wr(4'h1, 8'h31);
    measure(1);
    check("crystal wait", len, 500);
    measure(2);
    check("calibration start", len, 1);
    calibrationDone = 1'b1;
    measure(0);
    calibrationDone = 1'b0;
    check("reinit sync", {nSync[7:0], len[7:0]}, 16'h0105);
    wr(4'h1, 8'h30);
    wr(4'h0, 8'h04);
    rd(4'h0, 8'h04);
    for (c = 0; c < 9; c++) begin
      wr(4'h2, 8'(1 << c));
      wr(4'h3, 8'(c == 8));
      check("soft resets", softVec, 16'(1 << c));
    end
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h09);
    closeOut();
  end
endmodule // global_config_reset_control_bench
bind global_config_reset_control global_config_reset_control_chk
  #(.SQUELCH_COUNT(SQUELCH_COUNT)) chk_u (.*);
